/* File: src/sd_host_data_fifo_status.sv */
/*
 * data path status and fifo status registers of the card host.
 * assumes the data engine, on core_clk, reports events as one-cycle
 * pulses and progress as levels; card pins arrive asynchronously.
 */
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module sd_host_data_fifo_status #(
    parameter int FIFO_BYTES = sd_stat_pkg::FIFO_BYTES,
    parameter int COUNT_W    = sd_stat_pkg::COUNT_W
) (
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // register port
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    // settings from the data control register
    input  wire logic [1:0]  transfer_direction,
    input  wire logic        dma_select,
    // data engine events and levels
    input  wire logic        cmd_sent,
    input  wire logic        read_wait_start,
    input  wire logic        crc_token_bad,
    input  wire logic        rx_crc_bad,
    input  wire logic        data_timeout,
    input  wire logic        data_count_zero,
    input  wire logic        rx_last_byte,
    input  wire logic        fifo_fail,
    input  wire logic        fifo_fail_last,
    input  wire logic        tx_active,
    input  wire logic        rx_active,
    // fifo byte movements
    input  wire logic        fifo_push,
    input  wire logic        fifo_pop,
    // card pins
    input  wire logic        card_clk,
    input  wire logic        card_dat0,
    input  wire logic        card_dat1,
    // outputs to the data path and dma
    output logic             read_wait_active,
    output logic             fifo_flush,
    output logic             dma_req
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    typedef enum logic [1:0] {
        B_IDLE,
        B_WINDOW,
        B_BUSY
    } busy_state_e;

    localparam logic [COUNT_W-1:0] FULL_LVL = COUNT_W'(FIFO_BYTES);
    localparam logic [COUNT_W-1:0] HALF_LVL =
        COUNT_W'(sd_stat_pkg::HALF_BYTES);
    localparam logic [sd_stat_pkg::EDGE_CNT_W-1:0] LAST_EDGE =
        sd_stat_pkg::EDGE_CNT_W'(sd_stat_pkg::NO_BUSY_EDGES - 1);

    busy_state_e                      busy_state;
    logic [sd_stat_pkg::EDGE_CNT_W-1:0] edge_cnt;
    logic [2:0]                       pins_sync;
    logic                             clk_prev;
    logic                             dat1_prev;
    logic                             clk_rise;
    logic                             dat1_fall;
    logic                             busy_low;
    logic                             no_busy_set;
    logic                             busy_end_set;
    logic                             irq_set;

    logic                             no_busy_seen;
    logic                             card_irq_seen;
    logic                             write_crc_token_error;
    logic                             read_crc_error;
    logic                             data_timeout_flag;
    logic                             transfer_finished;
    logic                             busy_ended;
    logic                             rx_final_data;
    logic [1:0]                       fifo_error_code;

    logic                             wr_data_stat;
    logic                             wr_fifo_stat;
    logic [31:0]                      clr_data;
    logic [31:0]                      clr_fifo;
    logic [COUNT_W-1:0]               fifo_byte_count;
    logic                             tx_space_available;
    logic                             rx_data_available;
    logic                             tx_half_level;
    logic                             tx_fifo_empty;
    logic                             rx_fifo_full;
    logic                             rx_half_level;
    logic [31:0]                      data_path_status;
    logic [31:0]                      fifo_level_status;

    // ****************************************************************
    // card pins into the core clock domain
    // ****************************************************************
    sd_sync2 #(
        .WIDTH    (3)
    ) pin_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .pin_in   ({card_dat1, card_dat0, card_clk}),
        .pin_sync (pins_sync)
    );

    // edge finders look at the synchronised level only
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            clk_prev  <= 1'b1;
            dat1_prev <= 1'b1;
        end else if (ce) begin
            clk_prev  <= pins_sync[0];
            dat1_prev <= pins_sync[2];
        end
    end

    assign clk_rise  = pins_sync[0] && !clk_prev;
    assign dat1_fall = dat1_prev && !pins_sync[2];
    assign busy_low  = !pins_sync[1];

    // ****************************************************************
    // busy check after a command
    // ****************************************************************
    // the window counts card clock edges, so a slow card clock
    // stretches it; a stopped card clock holds the window open
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            busy_state <= B_IDLE;
            edge_cnt   <= '0;
        end else if (ce) begin
            case (busy_state)
                B_IDLE: begin
                    edge_cnt <= '0;
                    if (cmd_sent &&
                        transfer_direction == sd_stat_pkg::DIR_BUSY) begin
                        busy_state <= B_WINDOW;
                    end
                end
                B_WINDOW: begin
                    if (busy_low) begin
                        busy_state <= B_BUSY;
                    end else if (clk_rise) begin
                        edge_cnt <= edge_cnt + 1'b1;
                        if (edge_cnt == LAST_EDGE) begin
                            busy_state <= B_IDLE;
                        end
                    end
                end
                B_BUSY: begin
                    if (!busy_low) begin
                        busy_state <= B_IDLE;
                    end
                end
                default: begin
                    busy_state <= B_IDLE;
                end
            endcase
        end
    end

    assign no_busy_set  = busy_state == B_WINDOW && !busy_low &&
                          clk_rise && edge_cnt == LAST_EDGE;
    assign busy_end_set = busy_state == B_BUSY && !busy_low;

    // interrupt shows as dat1 pulled low outside a data transfer
    assign irq_set = dat1_fall && !tx_active && !rx_active;

    // ****************************************************************
    // register decode
    // ****************************************************************
    assign wr_data_stat = wr_en && addr == sd_stat_pkg::DATA_STATUS_OFF;
    assign wr_fifo_stat = wr_en && addr == sd_stat_pkg::FIFO_STATUS_OFF;
    // zero bits clear nothing; other registers are never touched
    assign clr_data = wr_data_stat ? wr_data : '0;
    assign clr_fifo = wr_fifo_stat ? wr_data : '0;

    // ****************************************************************
    // sticky data path flags, set wins over clear
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            no_busy_seen          <= 1'b0;
            card_irq_seen         <= 1'b0;
            write_crc_token_error <= 1'b0;
            read_crc_error        <= 1'b0;
            data_timeout_flag     <= 1'b0;
            transfer_finished     <= 1'b0;
            busy_ended            <= 1'b0;
        end else if (ce) begin
            no_busy_seen <= no_busy_set ||
                (no_busy_seen && !clr_data[sd_stat_pkg::NO_BUSY_BIT]);
            card_irq_seen <= irq_set ||
                (card_irq_seen &&
                 !clr_data[sd_stat_pkg::CARD_IRQ_BIT]);
            write_crc_token_error <= crc_token_bad ||
                (write_crc_token_error &&
                 !clr_data[sd_stat_pkg::WR_CRC_BIT]);
            read_crc_error <= rx_crc_bad ||
                (read_crc_error &&
                 !clr_data[sd_stat_pkg::RD_CRC_BIT]);
            data_timeout_flag <= data_timeout ||
                (data_timeout_flag &&
                 !clr_data[sd_stat_pkg::TIMEOUT_BIT]);
            transfer_finished <= data_count_zero ||
                (transfer_finished &&
                 !clr_data[sd_stat_pkg::FINISHED_BIT]);
            busy_ended <= busy_end_set ||
                (busy_ended && !clr_data[sd_stat_pkg::BUSY_END_BIT]);
        end
    end

    // ****************************************************************
    // read wait request
    // ****************************************************************
    // the flag is the request itself, so clearing it stops the request
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            read_wait_active <= 1'b0;
        end else if (ce) begin
            read_wait_active <= read_wait_start ||
                (read_wait_active &&
                 !clr_data[sd_stat_pkg::READ_WAIT_BIT]);
        end
    end

    // ****************************************************************
    // fifo flush and error code
    // ****************************************************************
    // flush stands one cycle, so it reads back as zero afterwards
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fifo_flush <= 1'b0;
        end else if (ce) begin
            fifo_flush <= clr_fifo[sd_stat_pkg::FLUSH_BIT];
        end
    end

    // each code bit clears on its own one; a new failure wins
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fifo_error_code <= sd_stat_pkg::ERR_NONE;
        end else if (ce) begin
            if (fifo_fail_last) begin
                fifo_error_code <= sd_stat_pkg::ERR_LAST_XFER;
            end else if (fifo_fail) begin
                fifo_error_code <= sd_stat_pkg::ERR_FIFO;
            end else begin
                fifo_error_code <= fifo_error_code &
                    ~clr_fifo[sd_stat_pkg::ERR_CODE_LSB +: 2];
            end
        end
    end

    // software reads an oversized last byte, then clears and flushes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_final_data <= 1'b0;
        end else if (ce) begin
            rx_final_data <= rx_last_byte ||
                (rx_final_data &&
                 !clr_fifo[sd_stat_pkg::RX_FINAL_BIT]);
        end
    end

    // ****************************************************************
    // fifo level and level flags
    // ****************************************************************
    sd_fifo_level #(
        .DEPTH    (FIFO_BYTES),
        .COUNT_W  (COUNT_W)
    ) level (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .push     (fifo_push),
        .pop      (fifo_pop),
        .flush    (fifo_flush),
        .count    (fifo_byte_count)
    );

    assign tx_space_available =
        transfer_direction == sd_stat_pkg::DIR_TX &&
        fifo_byte_count != FULL_LVL;
    assign rx_data_available =
        transfer_direction == sd_stat_pkg::DIR_RX &&
        fifo_byte_count != '0;
    assign tx_half_level = fifo_byte_count <= HALF_LVL;
    assign tx_fifo_empty = fifo_byte_count == '0;
    assign rx_fifo_full  = fifo_byte_count == FULL_LVL;
    assign rx_half_level = fifo_byte_count >= HALF_LVL;

    // dma is registered, one cycle behind the level
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dma_req <= 1'b0;
        end else if (ce) begin
            dma_req <= dma_select &&
                (tx_space_available || rx_data_available);
        end
    end

    // ****************************************************************
    // read back
    // ****************************************************************
    always_comb begin
        data_path_status = sd_stat_pkg::REG_RESET;
        data_path_status[sd_stat_pkg::NO_BUSY_BIT]   = no_busy_seen;
        data_path_status[sd_stat_pkg::READ_WAIT_BIT] = read_wait_active;
        data_path_status[sd_stat_pkg::CARD_IRQ_BIT]  = card_irq_seen;
        data_path_status[sd_stat_pkg::WR_CRC_BIT]  = write_crc_token_error;
        data_path_status[sd_stat_pkg::RD_CRC_BIT]    = read_crc_error;
        data_path_status[sd_stat_pkg::TIMEOUT_BIT]   = data_timeout_flag;
        data_path_status[sd_stat_pkg::FINISHED_BIT]  = transfer_finished;
        data_path_status[sd_stat_pkg::BUSY_END_BIT]  = busy_ended;
        data_path_status[sd_stat_pkg::TX_ON_BIT]     = tx_active;
        data_path_status[sd_stat_pkg::RX_ON_BIT]     = rx_active;
    end

    always_comb begin
        fifo_level_status = sd_stat_pkg::REG_RESET;
        fifo_level_status[sd_stat_pkg::FLUSH_BIT]     = fifo_flush;
        fifo_level_status[sd_stat_pkg::ERR_CODE_LSB +: 2] = fifo_error_code;
        fifo_level_status[sd_stat_pkg::TX_AVAIL_BIT]  = tx_space_available;
        fifo_level_status[sd_stat_pkg::RX_AVAIL_BIT]  = rx_data_available;
        fifo_level_status[sd_stat_pkg::TX_HALF_BIT]   = tx_half_level;
        fifo_level_status[sd_stat_pkg::TX_EMPTY_BIT]  = tx_fifo_empty;
        fifo_level_status[sd_stat_pkg::RX_FINAL_BIT]  = rx_final_data;
        fifo_level_status[sd_stat_pkg::RX_FULL_BIT]   = rx_fifo_full;
        fifo_level_status[sd_stat_pkg::RX_HALF_BIT]   = rx_half_level;
        fifo_level_status[sd_stat_pkg::COUNT_LSB +: COUNT_W] =
            fifo_byte_count;
    end

    // data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rd_data <= sd_stat_pkg::REG_RESET;
        end else if (ce) begin
            if (!rd_en) begin
                rd_data <= '0;
            end else if (addr == sd_stat_pkg::DATA_STATUS_OFF) begin
                rd_data <= data_path_status;
            end else if (addr == sd_stat_pkg::FIFO_STATUS_OFF) begin
                rd_data <= fifo_level_status;
            end else begin
                rd_data <= '0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/sd_stat_pkg.sv */
/*
 * constants for the data path and fifo status registers of the card host.
 * assumes byte addresses on the register port and a 20 MHz core clock.
 */
package sd_stat_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [31:0] DATA_STATUS_OFF = 32'h5a00_0034;
    localparam logic [31:0] FIFO_STATUS_OFF = 32'h5a00_0038;
    localparam logic [31:0] REG_RESET       = 32'h0000_0000;

    // ****************************************************************
    // data path status fields
    // ****************************************************************
    localparam int NO_BUSY_BIT   = 11;
    localparam int READ_WAIT_BIT = 10;
    localparam int CARD_IRQ_BIT  = 9;
    localparam int WR_CRC_BIT    = 7;
    localparam int RD_CRC_BIT    = 6;
    localparam int TIMEOUT_BIT   = 5;
    localparam int FINISHED_BIT  = 4;
    localparam int BUSY_END_BIT  = 3;
    localparam int TX_ON_BIT     = 1;
    localparam int RX_ON_BIT     = 0;

    // ****************************************************************
    // fifo status fields
    // ****************************************************************
    localparam int FLUSH_BIT      = 16;
    localparam int ERR_CODE_LSB   = 14;
    localparam int TX_AVAIL_BIT   = 13;
    localparam int RX_AVAIL_BIT   = 12;
    localparam int TX_HALF_BIT    = 11;
    localparam int TX_EMPTY_BIT   = 10;
    localparam int RX_FINAL_BIT   = 9;
    localparam int RX_FULL_BIT    = 8;
    localparam int RX_HALF_BIT    = 7;
    localparam int COUNT_LSB      = 0;
    localparam logic [1:0] ERR_NONE      = 2'h0;
    localparam logic [1:0] ERR_FIFO      = 2'h1;
    localparam logic [1:0] ERR_LAST_XFER = 2'h2;

    // ****************************************************************
    // fifo geometry and levels
    // ****************************************************************
    localparam int FIFO_BYTES = 64;
    localparam int COUNT_W    = 7;
    localparam int HALF_BYTES = 32;

    // ****************************************************************
    // transfer direction codes
    // ****************************************************************
    localparam logic [1:0] DIR_NONE = 2'h0;
    localparam logic [1:0] DIR_BUSY = 2'h1;
    localparam logic [1:0] DIR_RX   = 2'h2;
    localparam logic [1:0] DIR_TX   = 2'h3;

    // ****************************************************************
    // busy window, counted in card clock rising edges
    // ****************************************************************
    localparam int         NO_BUSY_EDGES = 16;
    localparam int         EDGE_CNT_W    = 5;
endpackage

/* File: src/sd_sync2.sv */
/*
 * two stage synchroniser for card pins, with clock enable.
 * assumes the inputs are asynchronous to core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module sd_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    // pins in, clean levels out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta;

    // first stage is read by the second stage only
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            meta     <= '1;
            pin_sync <= '1;
        end else if (ce) begin
            meta     <= pin_in;
            pin_sync <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: src/sd_fifo_level.sv */
/*
 * byte level of the data fifo: counts pushes and pops, flush empties it.
 * assumes the data path never pushes when full nor pops when empty.
 */
`timescale 1ns/10ps
`default_nettype none
module sd_fifo_level #(
    parameter int DEPTH   = sd_stat_pkg::FIFO_BYTES,
    parameter int COUNT_W = sd_stat_pkg::COUNT_W
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               ce,
    // byte movements
    input  wire logic               push,
    input  wire logic               pop,
    input  wire logic               flush,
    // level
    output logic      [COUNT_W-1:0] count
);
    localparam logic [COUNT_W-1:0] TOP = COUNT_W'(DEPTH);

    // flush wins over a byte moving in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            count <= '0;
        end else if (ce) begin
            if (flush) begin
                count <= '0;
            end else if (push && !pop && count != TOP) begin
                count <= count + 1'b1;
            end else if (pop && !push && count != '0) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/sd_stat_monitor.sv */
/* checker for the status block; sees only the top module's ports */
`timescale 1ns/10ps
`default_nettype none
module sd_stat_monitor (
    // clock, reset, register port
    input wire logic        core_clk, rst_b, wr_en, rd_en,
    input wire logic [31:0] addr, wr_data, rd_data,
    // controls, events, outputs
    input wire logic        dma_select, read_wait_start, rx_crc_bad,
    input wire logic        tx_active, rx_active,
    input wire logic        read_wait_active, fifo_flush, dma_req
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic dw, fw, dr;
    assign dw = wr_en && addr == sd_stat_pkg::DATA_STATUS_OFF;
    assign fw = wr_en && addr == sd_stat_pkg::FIFO_STATUS_OFF;
    assign dr = rd_en && addr == sd_stat_pkg::DATA_STATUS_OFF;
    a_flush_start: assert property (fw && wr_data[16] |=> fifo_flush)
        else $error("flush pulse missing");
    a_flush_once: assert property (fifo_flush |=> !fifo_flush)
        else $error("flush pulse too long");
    a_rwait_set: assert property (read_wait_start |=> read_wait_active)
        else $error("read wait not raised");
    a_rwait_stop: assert property (dw && wr_data[10] && !read_wait_start
        |=> !read_wait_active) else $error("read wait not stopped");
    a_rwait_hold: assert property (read_wait_active
        && !(dw && wr_data[10]) |=> read_wait_active)
        else $error("read wait dropped");
    a_dma_off: assert property (!dma_select |=> !dma_req)
        else $error("dma request without dma");
    a_live_progress: assert property (dr
        |=> rd_data[1:0] == $past({tx_active, rx_active}))
        else $error("progress bits wrong");
    a_crc_sticky: assert property (rx_crc_bad ##1 !dw ##1 dr
        |=> rd_data[6]) else $error("crc flag not set");
    a_unmapped_zero: assert property (rd_en && !dr &&
        addr != sd_stat_pkg::FIFO_STATUS_OFF |=> rd_data == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind sd_host_data_fifo_status sd_stat_monitor i_sd_stat_monitor (
    .core_clk, .rst_b, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
    .dma_select, .read_wait_start, .rx_crc_bad, .tx_active, .rx_active,
    .read_wait_active, .fifo_flush, .dma_req);
`default_nettype wire

/* File: verif/sd_card_model.sv */
/* card on the far side: clock only within frames, busy and irq lines.
   assumes the bench tells it when to run, stall busy or interrupt. */
`timescale 1ns/10ps
`default_nettype none
module sd_card_model (
    input  wire logic run, busy, irq,
    output logic      card_clk,
    output wire logic card_dat0, card_dat1
);
    // odd start offset keeps the card clock unrelated to core_clk
    initial begin
        card_clk = 1'b0;
        #37;
        forever begin
            #200;
            card_clk = run ? ~card_clk : 1'b0;
        end
    end
    // lines are pulled up when the card lets go
    assign card_dat0 = ~busy;
    assign card_dat1 = ~irq;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
/* testbench: register reads and writes, event pulses, fifo levels.
   assumes the card model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [31:0] DS = sd_stat_pkg::DATA_STATUS_OFF;
    localparam logic [31:0] FS = sd_stat_pkg::FIFO_STATUS_OFF;
    localparam logic [1:0]  TX = sd_stat_pkg::DIR_TX;
    logic core_clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, dma_select = 0;
    logic run = 0, busy = 0, irq = 0, card_clk, card_dat0, card_dat1;
    logic read_wait_active, fifo_flush, dma_req;
    logic [31:0] addr = 0, wr_data = 0, rd_data;
    logic [1:0]  transfer_direction = 0, act = 0;
    logic [10:0] pl = 0;
    int failures = 0, n_checks = 0, cycles = 0;
    sd_host_data_fifo_status i_sd_host_data_fifo_status (.core_clk, .rst_b,
        .ce(1'b1), .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .transfer_direction, .dma_select, .cmd_sent(pl[8]),
        .read_wait_start(pl[7]), .crc_token_bad(pl[6]), .rx_crc_bad(pl[5]),
        .data_timeout(pl[4]), .data_count_zero(pl[3]), .rx_last_byte(pl[2]),
        .fifo_fail(pl[1]), .fifo_fail_last(pl[0]), .tx_active(act[1]),
        .rx_active(act[0]), .fifo_push(pl[10]), .fifo_pop(pl[9]), .card_clk,
        .card_dat0, .card_dat1, .read_wait_active, .fifo_flush, .dma_req);
    sd_card_model i_sd_card_model (.run, .busy, .irq, .card_clk,
        .card_dat0, .card_dat1);
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end
    task automatic results;
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {wr_en, addr, wr_data} <= {1'b1, a, d};
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        {rd_en, addr} <= {1'b1, a};
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
    endtask
    task automatic pulse(input logic [10:0] v);
        @(posedge core_clk);
        pl <= v;
        @(posedge core_clk);
        pl <= 11'h0;
    endtask
    function automatic logic [31:0] lvl(input int n, input logic [1:0] d);
        lvl = 32'(n);
        lvl[13] = d == TX && n < 64;
        lvl[12] = d == sd_stat_pkg::DIR_RX && n > 0;
        {lvl[11], lvl[10], lvl[8], lvl[7]} =
            {n <= 32, n == 0, n == 64, n >= 32};
    endfunction
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(DS, 32'h0);
        rd(FS, lvl(0, 2'h0));
        rd(32'h5a00_003c, 32'h0);
        @(posedge core_clk) act <= 2'h3;
        pulse(11'h0f8);
        rd(DS, 32'h4f3);
        wr(DS, 32'h0);
        rd(DS, 32'h4f3);
        wr(DS, 32'hffff_ffff);
        act <= 2'h0;
        rd(DS, 32'h0);
        irq <= 1'b1;
        repeat (8) @(posedge core_clk);
        irq <= 1'b0;
        rd(DS, 32'h200);
        wr(DS, 32'h200);
        transfer_direction <= sd_stat_pkg::DIR_BUSY;
        run <= 1'b1;
        pulse(11'h100);
        repeat (160) @(posedge core_clk);
        rd(DS, 32'h800);
        wr(DS, 32'h800);
        busy <= 1'b1;
        pulse(11'h100);
        repeat (160) @(posedge core_clk);
        rd(DS, 32'h0);
        @(posedge core_clk) busy <= 1'b0;
        repeat (24) @(posedge core_clk);
        rd(DS, 32'h8);
        wr(DS, 32'h8);
        run <= 1'b0;
        {transfer_direction, dma_select} <= {sd_stat_pkg::DIR_RX, 1'b1};
        for (int n = 0; n <= 64; n++) begin
            rd(FS, lvl(n, sd_stat_pkg::DIR_RX));
            chk(32'(dma_req), 32'(n > 0));
            pulse(n < 64 ? 11'h400 : 11'h600);
        end
        transfer_direction <= TX;
        for (int n = 64; n >= 0; n--) begin
            rd(FS, lvl(n, TX));
            chk(32'(dma_req), 32'(n < 64));
            if (n > 0) pulse(11'h200);
        end
        pulse(11'h002);
        dma_select <= 1'b0;
        rd(FS, lvl(0, TX) | 32'h4000);
        chk(32'(dma_req), 32'h0);
        wr(FS, 32'h0000_c07f);
        rd(FS, lvl(0, TX));
        pulse(11'h407);
        rd(FS, lvl(1, TX) | 32'h8200);
        wr(FS, 32'h0001_c200);
        #1 chk(32'(fifo_flush), 32'h1);
        rd(FS, lvl(0, TX));
        results();
    end
endmodule
`default_nettype wire
